// >>> verilog/uhb_pkg.sv
// shared constants and types of the uart host bus pin interface
package uhb_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int ERR_W = 3;
    localparam int SRC_W = 4;
    localparam int DIV_W = 16;
    localparam int ISA_AW = 10;
    localparam int REQ_W = 3;
    // receive error bit positions on the high data lines
    localparam int ERR_PARITY = 0;
    localparam int ERR_FRAME = 1;
    localparam int ERR_BREAK = 2;
    // modem control bits used here
    localparam int MCR_OUT2 = 3;
    localparam int MCR_PRESCALE = 7;
    // request line positions
    localparam int REQ_FIRST = 0;
    localparam int REQ_SECOND = 1;
    localparam int REQ_THIRD = 2;
    // prescaler and divisor counts
    localparam logic [1:0] PRE_LAST = 2'h3;
    localparam logic [1:0] PRE_STEP = 2'h1;
    localparam logic [DIV_W-1:0] DIV_ONE = 16'h0001;
    // isa port bases, compared on address bits 9..3
    localparam logic [ISA_AW-1:0] COM1_BASE = 10'h3f8;
    localparam logic [ISA_AW-1:0] COM2_BASE = 10'h2f8;
    localparam logic [ISA_AW-1:0] COM3_BASE = 10'h3e8;
    localparam logic [ISA_AW-1:0] COM4_BASE = 10'h2e8;
    localparam logic [ISA_AW-1:0] PRINTER1_DECODE_N_BASE = 10'h378;
    localparam logic [ISA_AW-1:0] PRINTER2_DECODE_N_BASE = 10'h278;
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_READ = 2'b01,
        ACC_WRITE = 2'b10
    } uhb_acc_t;
endpackage

// >>> verilog/uhb_rate_gen.sv
// prescaler and rate divider giving the 16x sampling tick
module uhb_rate_gen import uhb_pkg::*; (
    input logic clk,
    input logic rst_n,
    input logic div4,
    input logic [DIV_W-1:0] divisor,
    output logic tick
);
    typedef struct packed {
        logic [1:0] pre;
        logic [DIV_W-1:0] cnt;
        logic tick;
    } uhb_rg_t;

    uhb_rg_t s;
    uhb_rg_t next_s;
    logic pre_en;

    ////////////////////////////////////////////////////////////////
    // divisor zero holds the tick off rather than running wild
    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        next_s.pre = s.pre + PRE_STEP;
        pre_en = !div4 || (s.pre == PRE_LAST);
        if (pre_en) begin
            if (s.cnt <= DIV_ONE) begin
                next_s.cnt = divisor;
                next_s.tick = (divisor != '0);
            end else begin
                next_s.cnt = s.cnt - DIV_ONE;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;
endmodule

// >>> verilog/uhb_isa_decode.sv
// isa com and printer port address decode
module uhb_isa_decode import uhb_pkg::*; (
    input logic [ISA_AW-1:0] addr,
    input logic [1:0] com_sel,
    input logic req_alt,
    output logic com_hit,
    output logic printer1_decode_n_hit,
    output logic printer2_decode_n_hit,
    output logic [REQ_W-1:0] req_pick
);
    logic [ISA_AW-1:0] com_base;

    // an eight-byte window match on bits 9..3
    function automatic logic port_match(input logic [ISA_AW-1:0] a, input logic [ISA_AW-1:0] base);
        port_match = (a[ISA_AW-1:ADDR_W] == base[ISA_AW-1:ADDR_W]);
    endfunction

    ////////////////////////////////////////////////////////////////
    // port select inputs pick one of the four com bases
    always_comb begin
        case (com_sel)
            2'b00: com_base = COM1_BASE;
            2'b01: com_base = COM2_BASE;
            2'b10: com_base = COM3_BASE;
            default: com_base = COM4_BASE;
        endcase
    end

    assign com_hit = port_match(addr, com_base);
    assign printer1_decode_n_hit = port_match(addr, PRINTER1_DECODE_N_BASE);
    assign printer2_decode_n_hit = port_match(addr, PRINTER2_DECODE_N_BASE);

    // com1/3 share the first line, com2/4 the second, alt forces the third
    always_comb begin
        req_pick = '0;
        if (req_alt) begin
            req_pick[REQ_THIRD] = 1'b1;
        end else if (!com_sel[0]) begin
            req_pick[REQ_FIRST] = 1'b1;
        end else begin
            req_pick[REQ_SECOND] = 1'b1;
        end
    end
endmodule

// >>> verilog/uhb_host_port.sv
// host bus pin interface of the uart: strobe-bus and isa modes
module uhb_host_port import uhb_pkg::*; (
    input logic CLK,
    input logic RESETN,
    input logic BUS_MODE_N,
    input logic WIDTH_PICK,
    input logic PRESCALE_PICK,
    input logic [ADDR_W-1:0] ADDR,
    input logic READ_STROBE_N,
    input logic READ_STROBE_HI,
    input logic WRITE_STROBE_N,
    input logic WRITE_STROBE_HI,
    input logic CHIP_PICK_HI_A,
    input logic CHIP_PICK_HI_B,
    input logic CHIP_PICK_LOW,
    input logic ADDR_LATCH_STROBE_N,
    input logic ISA_A4,
    input logic ISA_A9,
    input logic COM_PICK_ONE,
    input logic COM_PICK_TWO,
    input logic COM_PICK_THREE,
    input logic [DATA_W-1:0] DATA_IN,
    output logic [DATA_W-1:0] DATA_OUT,
    output logic DATA_OE,
    output logic PARITY_ERR_LINE,
    output logic FRAME_ERR_LINE,
    output logic ERR_LINES_OE,
    output logic BREAK_ERR_LINE,
    output logic BREAK_ERR_OE,
    output logic INT_REQ_FIRST,
    output logic INT_REQ_FIRST_OE,
    output logic RX_AVAIL_LOW,
    output logic RX_AVAIL_LOW_OE,
    output logic TX_SPACE_LOW,
    output logic TX_SPACE_LOW_OE,
    output logic RATE_GEN_OUT_N,
    output logic GP_OUT_TWO,
    output logic GP_OUT_TWO_OE,
    output logic [ADDR_W-1:0] REG_INDEX,
    output logic REG_RD,
    output logic REG_WR,
    output logic [DATA_W-1:0] REG_WDATA,
    input logic [DATA_W-1:0] REG_RDATA,
    input logic [ERR_W-1:0] RX_ERR,
    input logic [SRC_W-1:0] SRC_ACTIVE,
    input logic [SRC_W-1:0] IRQ_ENABLE,
    input logic RX_HOLD_FULL,
    input logic RX_FIFO_NONEMPTY,
    input logic TX_SPACE,
    input logic [DATA_W-1:0] MODEM_CTL,
    input logic [DIV_W-1:0] DIVISOR,
    output logic RX_SAMPLE_TICK
);
    typedef struct packed {
        uhb_acc_t acc;
        logic rd_prev;
        logic wr_prev;
        logic as_prev;
        logic rclk_prev;
        logic fresh;
        logic lat_sel;
        logic [ADDR_W-1:0] lat_idx;
        logic [ADDR_W-1:0] acc_idx;
        logic rd;
        logic wr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] dout;
        logic [ERR_W-1:0] err;
        logic irq;
        logic rx_low;
        logic tx_low;
        logic printer1_decode_n_n;
        logic printer2_decode_n_n;
        logic rx_tick;
        logic strap_div4;
        logic strap_done;
    } uhb_port_t;

    uhb_port_t s;
    uhb_port_t next_s;
    logic isa;
    logic wide;
    logic rd_lvl;
    logic wr_lvl;
    logic cs_ok;
    logic live_sel;
    logic eff_sel;
    logic [ADDR_W-1:0] eff_idx;
    logic [ISA_AW-1:0] isa_addr;
    logic com_hit;
    logic printer1_decode_n_hit;
    logic printer2_decode_n_hit;
    logic [REQ_W-1:0] req_pick;
    logic div4;
    logic rate_tick;
    logic req_gate;

    ////////////////////////////////////////////////////////////////
    // pin roles by mode
    assign isa = !BUS_MODE_N;
    assign wide = !WIDTH_PICK && !isa;
    // isa keeps only the low-active strobes, high pins are addresses
    assign rd_lvl = isa ? !READ_STROBE_N : (!READ_STROBE_N || READ_STROBE_HI);
    assign wr_lvl = isa ? !WRITE_STROBE_N : (!WRITE_STROBE_N || WRITE_STROBE_HI);
    assign cs_ok = CHIP_PICK_HI_A && CHIP_PICK_HI_B && !CHIP_PICK_LOW;
    assign isa_addr = {ISA_A9, WRITE_STROBE_HI, CHIP_PICK_LOW, CHIP_PICK_HI_B,
                       CHIP_PICK_HI_A, ISA_A4, READ_STROBE_HI, ADDR};
    assign live_sel = isa ? (com_hit && !ADDR_LATCH_STROBE_N) : cs_ok;
    // a fresh strobe latch wins, otherwise take the live pins at access start
    assign eff_sel = s.fresh ? s.lat_sel : live_sel;
    assign eff_idx = s.fresh ? s.lat_idx : ADDR;
    assign div4 = s.strap_div4 || MODEM_CTL[MCR_PRESCALE];
    assign req_gate = MODEM_CTL[MCR_OUT2];

    uhb_isa_decode u_decode (
        .addr(isa_addr),
        .com_sel({COM_PICK_TWO, COM_PICK_ONE}),
        .req_alt(COM_PICK_THREE),
        .com_hit(com_hit),
        .printer1_decode_n_hit(printer1_decode_n_hit),
        .printer2_decode_n_hit(printer2_decode_n_hit),
        .req_pick(req_pick)
    );

    uhb_rate_gen u_rate (
        .clk(CLK),
        .rst_n(RESETN),
        .div4(div4),
        .divisor(DIVISOR),
        .tick(rate_tick)
    );

    ////////////////////////////////////////////////////////////////
    // access sequencing, address latch, status and decode registers
    always_comb begin
        next_s = s;
        next_s.rd_prev = rd_lvl;
        next_s.wr_prev = wr_lvl;
        next_s.as_prev = ADDR_LATCH_STROBE_N;
        next_s.rclk_prev = COM_PICK_TWO;
        next_s.rd = 1'b0;
        next_s.wr = 1'b0;
        // strap caught once, one clock after reset release
        if (!s.strap_done) begin
            next_s.strap_div4 = !PRESCALE_PICK;
            next_s.strap_done = 1'b1;
        end
        case (s.acc)
            ACC_IDLE: begin
                // both strobes together start nothing, avoiding test-mode hazards
                if (rd_lvl && !s.rd_prev && !wr_lvl && eff_sel) begin
                    next_s.acc = ACC_READ;
                    next_s.acc_idx = eff_idx;
                    next_s.rd = 1'b1;
                end else if (wr_lvl && !s.wr_prev && !rd_lvl && eff_sel) begin
                    next_s.acc = ACC_WRITE;
                    next_s.acc_idx = eff_idx;
                    next_s.wdata = DATA_IN;
                end
            end
            ACC_READ: begin
                next_s.dout = REG_RDATA;
                next_s.err = RX_ERR;
                if (!rd_lvl) begin
                    next_s.acc = ACC_IDLE;
                    next_s.fresh = 1'b0;
                end
            end
            ACC_WRITE: begin
                // data tracked while active, committed on the trailing edge
                if (wr_lvl) begin
                    next_s.wdata = DATA_IN;
                end else begin
                    next_s.acc = ACC_IDLE;
                    next_s.wr = 1'b1;
                    next_s.fresh = 1'b0;
                end
            end
            default: begin
                next_s.acc = ACC_IDLE;
            end
        endcase
        // after the access steps so a new strobe fall wins over an access-end clear
        if (ADDR_LATCH_STROBE_N) begin
            next_s.fresh = 1'b0;
        end else if (s.as_prev) begin
            next_s.fresh = 1'b1;
            next_s.lat_sel = live_sel;
            next_s.lat_idx = ADDR;
        end
        next_s.irq = |(SRC_ACTIVE & IRQ_ENABLE);
        next_s.rx_low = !(RX_HOLD_FULL || RX_FIFO_NONEMPTY);
        next_s.tx_low = !TX_SPACE;
        next_s.printer1_decode_n_n = !(isa && printer1_decode_n_hit && !ADDR_LATCH_STROBE_N);
        next_s.printer2_decode_n_n = !(isa && printer2_decode_n_hit && !ADDR_LATCH_STROBE_N);
        // receiver clock: internal rate tick in isa, else external 16x edge
        next_s.rx_tick = isa ? rate_tick : (COM_PICK_TWO && !s.rclk_prev);
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            s <= '0;
            s.rd_prev <= 1'b0;
            // strobe history starts low: a tied-low strobe must not latch idle pins
            s.rx_low <= 1'b1;
            s.tx_low <= 1'b1;
            s.printer1_decode_n_n <= 1'b1;
            s.printer2_decode_n_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////
    // register set side
    assign REG_INDEX = s.acc_idx;
    assign REG_RD = s.rd;
    assign REG_WR = s.wr;
    assign REG_WDATA = s.wdata;
    assign RX_SAMPLE_TICK = s.rx_tick;

    // data bus and high data lines
    assign DATA_OUT = s.dout;
    assign DATA_OE = (s.acc == ACC_READ);
    assign PARITY_ERR_LINE = s.err[ERR_PARITY];
    assign FRAME_ERR_LINE = s.err[ERR_FRAME];
    assign ERR_LINES_OE = wide && (s.acc == ACC_READ);
    // the eleventh line carries three roles, picked by mode
    always_comb begin
        if (isa) begin
            BREAK_ERR_LINE = s.printer2_decode_n_n;
            BREAK_ERR_OE = 1'b1;
        end else if (wide) begin
            BREAK_ERR_LINE = s.err[ERR_BREAK];
            BREAK_ERR_OE = (s.acc == ACC_READ);
        end else begin
            BREAK_ERR_LINE = (s.acc != ACC_READ);
            BREAK_ERR_OE = 1'b1;
        end
    end

    // status pins double as three-state request lines in isa
    assign INT_REQ_FIRST = s.irq;
    assign RX_AVAIL_LOW = isa ? s.irq : s.rx_low;
    assign TX_SPACE_LOW = isa ? s.irq : s.tx_low;
    assign INT_REQ_FIRST_OE = !isa || (req_gate && req_pick[REQ_FIRST]);
    assign RX_AVAIL_LOW_OE = !isa || (req_gate && req_pick[REQ_SECOND]);
    assign TX_SPACE_LOW_OE = !isa || (req_gate && req_pick[REQ_THIRD]);

    // rate pin and general output
    assign RATE_GEN_OUT_N = isa ? s.printer1_decode_n_n : !rate_tick;
    assign GP_OUT_TWO = !MODEM_CTL[MCR_OUT2];
    assign GP_OUT_TWO_OE = !isa;

    ////////////////////////////////////////////////////////////////
    // checks on the block's own outputs and its latched address index
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    property p_read_start;
        (s.acc == ACC_IDLE) && rd_lvl && !s.rd_prev && !wr_lvl && eff_sel |=> REG_RD && DATA_OE;
    endproperty
    a_read_start: assert property (p_read_start) else $error("read start missed");

    property p_write_commit;
        (s.acc == ACC_WRITE) && !wr_lvl |=> REG_WR && (REG_WDATA == $past(s.wdata)) ##1 !REG_WR;
    endproperty
    a_write_commit: assert property (p_write_commit) else $error("write not committed");

    property p_write_hold;
        (s.acc == ACC_WRITE) && wr_lvl |=> !REG_WR;
    endproperty
    a_write_hold: assert property (p_write_hold) else $error("write stored early");

    property p_select_needed;
        !isa && (s.acc == ACC_IDLE) && !s.fresh && !cs_ok |=> !REG_RD && !DATA_OE;
    endproperty
    a_select_needed: assert property (p_select_needed) else $error("access while not selected");

    property p_irq;
        !isa ##1 1'b1 |-> INT_REQ_FIRST == $past(|(SRC_ACTIVE & IRQ_ENABLE));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt output wrong");

    property p_rx_ready;
        !isa && $past(RESETN) && $past(RX_HOLD_FULL || RX_FIFO_NONEMPTY) |-> !RX_AVAIL_LOW;
    endproperty
    a_rx_ready: assert property (p_rx_ready) else $error("rx ready not low");

    property p_tx_ready;
        !isa && $past(RESETN) && $past(TX_SPACE, 1) |-> !TX_SPACE_LOW;
    endproperty
    a_tx_ready: assert property (p_tx_ready) else $error("tx ready not low");

    property p_latch_hold;
        !isa && s.fresh && !ADDR_LATCH_STROBE_N ##1 !ADDR_LATCH_STROBE_N |-> $stable(s.lat_idx);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched address moved");

    property p_drive_off;
        !isa && !wide && DATA_OE |-> BREAK_ERR_LINE == 1'b0;
    endproperty
    a_drive_off: assert property (p_drive_off) else $error("drive-off not low on read");

    property p_narrow_err;
        !wide |-> !ERR_LINES_OE;
    endproperty
    a_narrow_err: assert property (p_narrow_err) else $error("error lines driven in 8-bit");

    property p_req_gate;
        isa && !req_gate |-> !INT_REQ_FIRST_OE && !RX_AVAIL_LOW_OE && !TX_SPACE_LOW_OE;
    endproperty
    a_req_gate: assert property (p_req_gate) else $error("request line enabled without gate");

    property p_isa_rx_clk;
        isa && $past(isa) && $past(rate_tick) |-> RX_SAMPLE_TICK;
    endproperty
    a_isa_rx_clk: assert property (p_isa_rx_clk) else $error("isa receiver tick missing");

    property p_bus_idle;
        DATA_OE |-> $past(rd_lvl);
    endproperty
    a_bus_idle: assert property (p_bus_idle) else $error("bus driven without read");

    c_read: cover property (REG_RD ##[1:20] !DATA_OE);
    c_write: cover property ((s.acc == ACC_WRITE) ##[1:20] REG_WR);
    c_isa_req: cover property (isa && req_gate && INT_REQ_FIRST_OE && INT_REQ_FIRST);
    c_latched: cover property (s.fresh && REG_RD);
endmodule

// >>> dv/uhb_host_model.sv
// host bus model: drives strobes, selects and address pins, samples the data bus
module uhb_host_model import uhb_pkg::*; (
    input wire logic clk,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [ERR_W-1:0] hi_bits,
    output logic [ADDR_W-1:0] addr,
    output logic rd_n,
    output logic rd_hi,
    output logic wr_n,
    output logic wr_hi,
    output logic pick_a,
    output logic pick_b,
    output logic pick_low,
    output logic latch_n,
    output logic a4,
    output logic a9,
    output logic [DATA_W-1:0] wdata
);
    timeunit 1ns;
    timeprecision 1ns;

    // unused strobes parked inactive, address strobe tied low
    initial begin
        addr = 3'h0;
        {rd_n, rd_hi, wr_n, wr_hi} = 4'b1010;
        {pick_a, pick_b, pick_low, a4, a9} = 5'h00;
        latch_n = 1'b0;
        wdata = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one pin map for both modes: in strobe mode bits 3 and 5..8 are read-high, picks, write-high
    // waits an edge first so it never meets a strobe release in one time step
    task automatic place(input logic [ISA_AW-1:0] a);
        @(posedge clk);
        #10;
        addr = a[2:0];
        {a9, wr_hi, pick_low, pick_b, pick_a, a4, rd_hi} = a[9:3];
    endtask

    // address strobe falls on pins a, then pins move to b
    task automatic latch(input logic [ISA_AW-1:0] a, input logic [ISA_AW-1:0] b);
        @(posedge clk);
        #10;
        latch_n = 1'b1;
        place(a);
        @(posedge clk);
        #10;
        latch_n = 1'b0;
        @(posedge clk);
        #10;
        place(b);
    endtask

    // strobe held n edges; data taken before release, released bus shows inverse
    task automatic access(input logic wr, input logic hi, input int n, input logic [DATA_W-1:0] wd,
                          output logic [DATA_W+ERR_W-1:0] got);
        @(posedge clk);
        #10;
        if (wr) begin
            wdata = wd;
            if (hi) wr_hi = 1'b1;
            else wr_n = 1'b0;
        end else if (hi) begin
            rd_hi = 1'b1;
        end else begin
            rd_n = 1'b0;
        end
        repeat (n) @(posedge clk);
        #10;
        got = {hi_bits, rdata};
        if (!hi) begin
            rd_n = 1'b1;
            wr_n = 1'b1;
        end else if (wr) begin
            wr_hi = 1'b0;
        end else begin
            rd_hi = 1'b0;
        end
        if (wr) wdata = ~wd;
    endtask
endmodule

// >>> dv/uart_host_bus_pin_interface_test.sv
// self-checking bench of the uart host bus pin interface
module uart_host_bus_pin_interface_test import uhb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK, RESETN, BUS_MODE_N, WIDTH_PICK, PRESCALE_PICK, COM_PICK_ONE, COM_PICK_TWO, COM_PICK_THREE;
    logic READ_STROBE_N, READ_STROBE_HI, WRITE_STROBE_N, WRITE_STROBE_HI, CHIP_PICK_HI_A, CHIP_PICK_HI_B;
    logic CHIP_PICK_LOW, ADDR_LATCH_STROBE_N, ISA_A4, ISA_A9, DATA_OE, PARITY_ERR_LINE, FRAME_ERR_LINE;
    logic ERR_LINES_OE, BREAK_ERR_LINE, BREAK_ERR_OE, INT_REQ_FIRST, INT_REQ_FIRST_OE, RX_AVAIL_LOW;
    logic RX_AVAIL_LOW_OE, TX_SPACE_LOW, TX_SPACE_LOW_OE, RATE_GEN_OUT_N, GP_OUT_TWO, GP_OUT_TWO_OE;
    logic REG_RD, REG_WR, RX_HOLD_FULL, RX_FIFO_NONEMPTY, TX_SPACE, RX_SAMPLE_TICK;
    logic [ADDR_W-1:0] ADDR, REG_INDEX;
    logic [DATA_W-1:0] DATA_IN, DATA_OUT, REG_WDATA, REG_RDATA, MODEM_CTL;
    logic [ERR_W-1:0] RX_ERR;
    logic [SRC_W-1:0] SRC_ACTIVE, IRQ_ENABLE;
    logic [DIV_W-1:0] DIVISOR;
    logic [DATA_W+ERR_W-1:0] got;
    int n_errors = 0, compares = 0, n_rd = 0, n_wr = 0, cycles = 0;

    // register set stand-in: contents follow the index
    assign REG_RDATA = {REG_INDEX, 5'h16};

    uhb_host_port dut_u (.CLK, .RESETN, .BUS_MODE_N, .WIDTH_PICK, .PRESCALE_PICK, .ADDR, .READ_STROBE_N,
        .READ_STROBE_HI, .WRITE_STROBE_N, .WRITE_STROBE_HI, .CHIP_PICK_HI_A, .CHIP_PICK_HI_B, .CHIP_PICK_LOW,
        .ADDR_LATCH_STROBE_N, .ISA_A4, .ISA_A9, .COM_PICK_ONE, .COM_PICK_TWO, .COM_PICK_THREE, .DATA_IN,
        .DATA_OUT, .DATA_OE, .PARITY_ERR_LINE, .FRAME_ERR_LINE, .ERR_LINES_OE, .BREAK_ERR_LINE, .BREAK_ERR_OE,
        .INT_REQ_FIRST, .INT_REQ_FIRST_OE, .RX_AVAIL_LOW, .RX_AVAIL_LOW_OE, .TX_SPACE_LOW, .TX_SPACE_LOW_OE,
        .RATE_GEN_OUT_N, .GP_OUT_TWO, .GP_OUT_TWO_OE, .REG_INDEX, .REG_RD, .REG_WR, .REG_WDATA, .REG_RDATA,
        .RX_ERR, .SRC_ACTIVE, .IRQ_ENABLE, .RX_HOLD_FULL, .RX_FIFO_NONEMPTY, .TX_SPACE, .MODEM_CTL,
        .DIVISOR, .RX_SAMPLE_TICK);

    uhb_host_model host_u (.clk(CLK), .rdata(DATA_OUT), .hi_bits({BREAK_ERR_LINE, FRAME_ERR_LINE,
        PARITY_ERR_LINE}), .addr(ADDR), .rd_n(READ_STROBE_N), .rd_hi(READ_STROBE_HI), .wr_n(WRITE_STROBE_N),
        .wr_hi(WRITE_STROBE_HI), .pick_a(CHIP_PICK_HI_A), .pick_b(CHIP_PICK_HI_B), .pick_low(CHIP_PICK_LOW),
        .latch_n(ADDR_LATCH_STROBE_N), .a4(ISA_A4), .a9(ISA_A9), .wdata(DATA_IN));

    always #50 CLK = ~CLK;

    ////////////////////////////////////////////////////////////////////////////
    // pulse counters and hang guard; the ceiling is well above the few hundred cycles used
    always @(posedge CLK) begin
        cycles++;
        if (REG_RD === 1'b1) n_rd++;
        if (REG_WR === 1'b1) n_wr++;
        if (cycles == 20000) begin
            n_errors++;
            final_report();
        end
    end

    task automatic chk1(input logic g, input logic e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk8(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic settle();
        repeat (2) @(posedge CLK);
        #10;
    endtask

    task automatic reset_dut();
        RESETN = 1'b0;
        repeat (12) @(posedge CLK);
        #10;
        RESETN = 1'b1;
        settle();
    endtask

    // one read; a refused read must leave the read pulse count alone
    task automatic rd(input logic hi, input logic [ADDR_W-1:0] idx, input logic pulse);
        int k;
        k = n_rd;
        host_u.access(1'b0, hi, 3, 8'h00, got);
        chk1(DATA_OE, pulse);
        chk1(ERR_LINES_OE, pulse & !WIDTH_PICK);
        if (pulse) chk8(got[DATA_W-1:0], {idx, 5'h16});
        chk1(logic'(n_rd != k), pulse);
    endtask

    // one write; the store lands only after the strobe ends
    task automatic wr(input logic hi, input logic [ADDR_W-1:0] idx, input logic [DATA_W-1:0] d);
        int k;
        k = n_wr;
        host_u.access(1'b1, hi, 2, d, got);
        chk1(logic'(n_wr != k), 1'b0);
        repeat (3) @(posedge CLK);
        #10;
        chk1(logic'(n_wr != k), 1'b1);
        chk8(REG_WDATA, d);
        chk8({5'h00, REG_INDEX}, {5'h00, idx});
    endtask

    // 40 cycles: rate output lows and receiver ticks from 5 external clock rises
    task automatic rate(input logic [DATA_W-1:0] lows, input logic [DIV_W-1:0] dv,
                        input logic [DATA_W-1:0] mc);
        int nl, nt;
        nl = 0;
        nt = 0;
        DIVISOR = dv;
        MODEM_CTL = mc;
        repeat (12) @(posedge CLK);
        for (int k = 0; k < 40; k++) begin
            @(posedge CLK);
            #10;
            nl += int'(RATE_GEN_OUT_N === 1'b0);
            nt += int'(RX_SAMPLE_TICK === 1'b1);
            COM_PICK_TWO = k[2];
        end
        @(posedge CLK);
        #10;
        COM_PICK_TWO = 1'b0;
        chk8(8'(nl), lows);
        chk8(8'(nt), 8'h05);
    endtask

    task automatic final_report();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        CLK = 1'b0;
        BUS_MODE_N = 1'b1;
        WIDTH_PICK = 1'b1;
        PRESCALE_PICK = 1'b1;
        {COM_PICK_ONE, COM_PICK_TWO, COM_PICK_THREE} = 3'h0;
        {RX_HOLD_FULL, RX_FIFO_NONEMPTY, TX_SPACE} = 3'h0;
        RX_ERR = 3'h0;
        SRC_ACTIVE = 4'h0;
        IRQ_ENABLE = 4'h0;
        MODEM_CTL = 8'h00;
        DIVISOR = 16'h0002;
        reset_dut();
        host_u.place(10'h065);
        rd(1'b0, 3'h5, 1'b1);
        chk1(got[DATA_W+ERR_BREAK], 1'b0);
        host_u.place(10'h062);
        rd(1'b1, 3'h2, 1'b1);
        host_u.place(10'h066);
        wr(1'b0, 3'h6, 8'h3c);
        host_u.place(10'h061);
        wr(1'b1, 3'h1, 8'hc3);
        for (int k = 0; k < 3; k++) begin
            host_u.place(k == 0 ? 10'h0e0 : (k == 1 ? 10'h040 : 10'h020));
            rd(1'b0, 3'h0, 1'b0);
        end
        $display("test strobe_access done");
        host_u.latch(10'h065, 10'h0e2);
        rd(1'b0, 3'h5, 1'b1);
        host_u.place(10'h063);
        rd(1'b0, 3'h3, 1'b1);
        WIDTH_PICK = 1'b0;
        RX_ERR = 3'h5;
        host_u.place(10'h064);
        rd(1'b0, 3'h4, 1'b1);
        chk8({5'h00, got[DATA_W+ERR_W-1:DATA_W]}, 8'h05);
        WIDTH_PICK = 1'b1;
        $display("test latch_and_width done");
        for (int i = 0; i < 4; i++) begin
            SRC_ACTIVE = 4'h1 << i;
            IRQ_ENABLE = (4'h1 << i) ^ {4{~i[0]}};
            RX_HOLD_FULL = i[0];
            RX_FIFO_NONEMPTY = i[1];
            TX_SPACE = i[1];
            settle();
            chk1(INT_REQ_FIRST, i[0]);
            chk1(RX_AVAIL_LOW, !(i[0] | i[1]));
            chk1(TX_SPACE_LOW, !i[1]);
        end
        $display("test status done");
        rate(8'd20, 16'h0002, 8'h00);
        rate(8'd10, 16'h0004, 8'h00);
        rate(8'd0, 16'h0000, 8'h00);
        rate(8'd5, 16'h0002, 8'h80);
        MODEM_CTL = 8'h00;
        PRESCALE_PICK = 1'b0;
        reset_dut();
        rate(8'd5, 16'h0002, 8'h00);
        $display("test rate done");
        BUS_MODE_N = 1'b0;
        MODEM_CTL = 8'h08;
        SRC_ACTIVE = 4'h2;
        IRQ_ENABLE = 4'h2;
        host_u.latch(10'h3fb, 10'h3fb);
        rd(1'b0, 3'h3, 1'b1);
        host_u.place(10'h2fb);
        rd(1'b0, 3'h3, 1'b0);
        chk1(GP_OUT_TWO_OE, 1'b0);
        // walk the request line picks: first, second, then the alternate third
        for (int j = 0; j < 3; j++) begin
            COM_PICK_ONE = j[0];
            COM_PICK_THREE = j[1];
            settle();
            chk1(INT_REQ_FIRST & INT_REQ_FIRST_OE, j == 0);
            chk1(RX_AVAIL_LOW & RX_AVAIL_LOW_OE, j == 1);
            chk1(TX_SPACE_LOW & TX_SPACE_LOW_OE, j == 2);
        end
        MODEM_CTL = 8'h00;
        settle();
        chk1(RX_AVAIL_LOW_OE, 1'b0);
        chk1(TX_SPACE_LOW_OE, 1'b0);
        host_u.place(10'h378);
        settle();
        chk1(RATE_GEN_OUT_N, 1'b0);
        chk1(BREAK_ERR_LINE, 1'b1);
        host_u.place(10'h278);
        settle();
        chk1(BREAK_ERR_LINE, 1'b0);
        chk1(RATE_GEN_OUT_N, 1'b1);
        $display("test isa done");
        final_report();
    end
endmodule
